// [logic/pot_slave.sv]
// Potentiometer end of the two-wire register port.
// Assumes i_lclk runs freely and much faster than the bus clock it samples.
`timescale 1ns/1ps
`include "pot_defs.svh"
module pot_slave
  import pot_pkg::*;
#(
  parameter logic [7:0]  NV_INIT   = `POT_NV_INIT,                  // Stored value at first use.
  parameter int unsigned NV_CYCLES = 32'(`POT_NV_CYCLES),           // Length of NV write.
  parameter int unsigned PWRUP     = `POT_PWRUP_CYCLES              // Power-up settle time.
) (
  input  wire logic       i_lclk,        // Link sampling clock.
  input  wire logic       i_rst_n,       // Power-on reset, active low.
  pot_bus_if.dev          bus,           // Two-wire bus.
  output logic [7:0]      o_wiper,       // Volatile wiper word.
  output logic [7:0]      o_nv_value,    // Stored initial value.
  output logic [7:0]      o_access_sel,  // Access selector word.
  output logic            o_nv_busy,     // NV write in progress.
  output logic            o_ready        // Power-up sequence finished.
);

  // ---------------------------------------------------------------------------
  // Pin sampling and condition detection
  // ---------------------------------------------------------------------------
  pot_dev_state_type state_r;
  pot_dev_state_type ret_r;
  logic [1:0]        pin_s;
  logic              scl_p_r;
  logic              sda_p_r;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              byte_end;
  logic [3:0]        cnt_r;
  logic [7:0]        sh_r;
  logic [7:0]        addr_r;
  logic              oe_r;
  logic              mack_r;
  logic [7:0]        wiper_r;
  logic [7:0]        sel_r;
  logic [7:0]        nv_r;
  logic              pend_r;
  logic [31:0]       wait_r;
  logic              wait_done;
  logic [7:0]        rd_val;

  pot_sync #(.WIDTH(2)) u_sync (
    .i_clk   (i_lclk),
    .i_rst_n (i_rst_n),
    .i_d     ({bus.scl, bus.sda}),
    .o_q     (pin_s)
  );

  // Previous sampled levels for edge and condition detection.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= pin_s[1];
      sda_p_r <= pin_s[0];
    end
  end

  // Data moving while the clock stays high marks start or stop.
  assign scl_rise  = pin_s[1] & ~scl_p_r;
  assign scl_fall  = ~pin_s[1] & scl_p_r;
  assign start_det = pin_s[1] & scl_p_r & sda_p_r & ~pin_s[0];
  assign stop_det  = pin_s[1] & scl_p_r & ~sda_p_r & pin_s[0];
  assign byte_end  = scl_fall && (cnt_r == 4'd8);
  assign wait_done = (state_r == S_PWRUP) ? (wait_r >= PWRUP - 1) : (wait_r >= NV_CYCLES - 1);

  // Read data decode, shared by the first byte and any follow-on byte.
  function automatic logic [7:0] read_val(input logic [7:0] a, input logic [7:0] sel,
                                          input logic [7:0] wip, input logic [7:0] nv);
    if (a == `POT_ADDR_WIPER) begin
      read_val = sel[`POT_SEL_VOL_BIT] ? wip : nv;
    end else if (a == `POT_ADDR_SEL) begin
      read_val = sel;
    end else begin
      read_val = `POT_RD_UNMAPPED;
    end
  endfunction

  assign rd_val = read_val(addr_r, sel_r, wiper_r, nv_r);

  // ---------------------------------------------------------------------------
  // Protocol state machine
  // ---------------------------------------------------------------------------
  // Power-up and the NV write are checked first, so the bus is deaf then.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= S_PWRUP;
      ret_r   <= S_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      addr_r  <= 8'h00;
      oe_r    <= 1'b0;
      mack_r  <= 1'b0;
    end else if (state_r == S_PWRUP) begin
      if (wait_done) begin
        state_r <= S_IDLE;
      end
    end else if (state_r == S_NVW) begin
      oe_r <= 1'b0;
      if (wait_done) begin
        state_r <= S_IDLE;
      end
    end else if (start_det) begin
      state_r <= S_ID;
      cnt_r   <= 4'h0;
      oe_r    <= 1'b0;
    end else if (stop_det) begin
      oe_r    <= 1'b0;
      state_r <= (state_r == S_DONE && pend_r) ? S_NVW : S_IDLE;
    end else begin
      case (state_r)
        S_ID, S_ADDR, S_WDATA: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], pin_s[0]};
            cnt_r <= cnt_r + 4'd1;
          end else if (byte_end) begin
            cnt_r <= 4'h0;
            if (state_r == S_ID && sh_r[7:1] != `POT_DEV_ID) begin
              state_r <= S_IDLE;
            end else begin
              oe_r    <= 1'b1;
              state_r <= S_ACK;
              if (state_r == S_ID) begin
                ret_r <= sh_r[0] ? S_RDATA : S_ADDR;
              end else if (state_r == S_ADDR) begin
                addr_r <= sh_r;
                ret_r  <= S_WDATA;
              end else begin
                ret_r <= S_DONE;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state_r <= ret_r;
            cnt_r   <= 4'h0;
            if (ret_r == S_RDATA) begin
              sh_r <= rd_val;
              oe_r <= ~rd_val[7];
            end else begin
              oe_r <= 1'b0;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            cnt_r <= cnt_r + 4'd1;
            if (cnt_r == 4'd7) begin
              oe_r    <= 1'b0;
              state_r <= S_RACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              oe_r <= ~sh_r[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_r <= ~pin_s[0];
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (mack_r) begin
              state_r <= S_RDATA;
              sh_r    <= rd_val;
              oe_r    <= ~rd_val[7];
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_DONE: begin
          if (scl_fall) begin
            state_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          oe_r <= 1'b0;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Settle and NV write timer
  // ---------------------------------------------------------------------------
  // One counter serves both waits; they can never overlap.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 32'd0;
    end else if (state_r == S_PWRUP || state_r == S_NVW) begin
      wait_r <= wait_r + 32'd1;
    end else begin
      wait_r <= 32'd0;
    end
  end

  // ---------------------------------------------------------------------------
  // Stored words
  // ---------------------------------------------------------------------------
  // Bus stores to wiper or selector happen only at the fall that ends a full data byte; the NV word stores at the stop.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wiper_r <= 8'h00;
      sel_r   <= `POT_SEL_RESET;
      nv_r    <= NV_INIT;
      pend_r  <= 1'b0;
    end else if (state_r == S_PWRUP) begin
      wiper_r <= nv_r;
    end else if (state_r == S_WDATA && byte_end && !start_det && !stop_det) begin
      if (addr_r == `POT_ADDR_WIPER) begin
        wiper_r <= sh_r;
        pend_r  <= (sel_r == 8'h00);
      end else if (addr_r == `POT_ADDR_SEL) begin
        sel_r <= sh_r;
      end
    end else if (state_r == S_DONE && stop_det && pend_r) begin
      nv_r   <= wiper_r;
      pend_r <= 1'b0;
    end else if (start_det || stop_det || (state_r == S_DONE && scl_fall)) begin
      pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wiper      <= 8'h00;
      o_nv_value   <= NV_INIT;
      o_access_sel <= `POT_SEL_RESET;
      o_nv_busy    <= 1'b0;
      o_ready      <= 1'b0;
    end else begin
      o_wiper      <= wiper_r;
      o_nv_value   <= nv_r;
      o_access_sel <= sel_r;
      o_nv_busy    <= (state_r == S_NVW);
      o_ready      <= (state_r != S_PWRUP);
    end
  end

  // Open-drain: the device only ever pulls low and never touches the clock.
  assign bus.sda_dev_o  = 1'b0;
  assign bus.sda_dev_oe = oe_r;
endmodule

// [logic/pot_defs.svh]
// Constants for the serial register port of the digital potentiometer.
// Assumes inclusion by bare name from every design file that needs figures.
//
// Function
// - Device is slave only, never drives clock.
// - All bytes shift most significant bit first.
// - Data changes only while clock is low.
// - Device releases data pin after power-up.
// - Ignore starts during power-up and NV write.
// - Stop after read or volatile write idles.
// - Finished NV write returns device to idle.
// - Transmitter releases; receiver acks ninth clock.
// - Device acks identification, address, write data.
// - Master acknowledges data bytes it reads; pot_master reads one byte and leaves its ninth clock unacknowledged.
// - Identification upper bits fixed; LSB selects direction.
// - Write: start, id, address, data, stop.
// - During NV write ignore lines, release data.
// - Last data bit fall loads wiper or selector.
// - Stop after address-0 write, selector zero: NV write.
// - Stores need valid bytes and exact pulses.
// - Read: start, id, address, restart, id read.
// - Master ends read with stop after byte.
// - Selector top bit picks wiper or NV word.
// - Access selector resets to zero.
// - Master never touches reserved address one; the testbench writes and reads it in t_reserved.
// - Selector zero: address-0 write fills both words.
// - Power-up copies NV value into wiper.
`ifndef POT_DEFS_SVH
`define POT_DEFS_SVH

// -----------------------------------------------------------------------------
// Register map and field layout
// -----------------------------------------------------------------------------
`define POT_DEV_ID        7'h28
`define POT_ADDR_WIPER    8'h00
`define POT_ADDR_RSVD     8'h01
`define POT_ADDR_SEL      8'h02
`define POT_SEL_RESET     8'h00
`define POT_SEL_VOL_BIT   7
`define POT_NV_INIT       8'h80
`define POT_RD_UNMAPPED   8'h00

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define POT_LCLK_PS       64'd6000
`define POT_NV_WRITE_NS   64'd5000000
`define POT_NV_CYCLES     ((`POT_NV_WRITE_NS * 64'd1000 + `POT_LCLK_PS - 64'd1) / `POT_LCLK_PS)
`define POT_PWRUP_CYCLES  32'd8
`define POT_MCLK_NS       32'd25
`define POT_SCL_QTR_NS    32'd625
`define POT_QTR_CYCLES    (`POT_SCL_QTR_NS / `POT_MCLK_NS)

`endif

// [logic/pot_pkg.sv]
// Types shared by both ends of the potentiometer register port.
// Assumes pot_defs.svh supplies all numeric constants.
package pot_pkg;

  // ---------------------------------------------------------------------------
  // Device state machine
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_PWRUP, S_IDLE, S_ID, S_ADDR, S_WDATA, S_ACK, S_DONE, S_RDATA, S_RACK, S_NVW
  } pot_dev_state_type;

  // ---------------------------------------------------------------------------
  // Master transaction items
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    IT_START, IT_WBYTE, IT_RBYTE, IT_STOP, IT_END
  } pot_item_type;

endpackage

// [logic/pot_bus_if.sv]
// Two-wire bus joining the master end and the potentiometer end.
// Assumes both ends drive the data line open-drain; the line idles high.
`timescale 1ns/1ps
interface pot_bus_if;
  logic scl;          // Clock, driven by the master only.
  logic sda_host_o;   // Master data out, always low.
  logic sda_host_oe;  // Master pulls data low while high.
  logic sda_dev_o;    // Device data out, always low.
  logic sda_dev_oe;   // Device pulls data low while high.
  logic sda;          // Resolved data line level.

  // Wired-AND with an implied pull-up.
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface

// [logic/pot_sync.sv]
// Two-stage synchroniser for pin levels entering a clock domain.
// Assumes the lines idle high, so reset loads ones.
`timescale 1ns/1ps
module pot_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clk,    // Destination clock.
  input  wire logic             i_rst_n,  // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] i_d,      // Asynchronous levels.
  output logic      [WIDTH-1:0] o_q       // Synchronised levels.
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '1;
      o_q    <= '1;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

// [logic/pot_master.sv]
// Master end: runs single-byte writes and reads over the two-wire bus.
// Assumes the user raises i_req only while o_busy is low.
`timescale 1ns/1ps
`include "pot_defs.svh"
module pot_master
  import pot_pkg::*;
#(
  parameter int unsigned QTR = `POT_QTR_CYCLES  // Clock cycles per quarter bit.
) (
  input  wire logic       i_mclk,      // System clock.
  input  wire logic       i_rst_n,     // Asynchronous reset, active low.
  pot_bus_if.host         bus,         // Two-wire bus.
  input  wire logic       i_req,       // Start a transaction, one-cycle pulse.
  input  wire logic       i_rw,        // 1 read, 0 write.
  input  wire logic [7:0] i_reg_addr,  // Register address.
  input  wire logic [7:0] i_wdata,     // Write data.
  output logic            o_busy,      // Transaction in flight.
  output logic            o_done,      // Completion pulse.
  output logic [7:0]      o_rdata,     // Read data.
  output logic            o_nack       // Device refused a byte.
);

  // ---------------------------------------------------------------------------
  // Clock divider
  // ---------------------------------------------------------------------------
  logic [31:0]  div_r;
  logic         tick;
  logic         sda_s;
  logic [2:0]   idx_r;
  logic [3:0]   slot_r;
  logic [1:0]   q_r;
  logic         rw_r;
  logic [7:0]   addr_r;
  logic [7:0]   wdata_r;
  logic [7:0]   rx_r;
  logic         scl_r;
  logic         low_r;
  logic         nk_r;
  pot_item_type item;
  logic [7:0]   tx;

  assign tick = (div_r == QTR - 1);

  // Divider restarts with each transaction so bit timing is repeatable.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 32'd0;
    end else if (!o_busy || tick) begin
      div_r <= 32'd0;
    end else begin
      div_r <= div_r + 32'd1;
    end
  end

  pot_sync #(.WIDTH(1)) u_sync (
    .i_clk   (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     (bus.sda),
    .o_q     (sda_s)
  );

  // ---------------------------------------------------------------------------
  // Transaction sequence
  // ---------------------------------------------------------------------------
  // Write: start, id, addr, data, stop. Read: start, id, addr, restart, id with read, read byte, stop.
  always_comb begin
    item = IT_END;
    tx   = 8'h00;
    case (idx_r)
      3'd0: item = IT_START;
      3'd1: begin
        item = IT_WBYTE;
        tx   = {`POT_DEV_ID, 1'b0};
      end
      3'd2: begin
        item = IT_WBYTE;
        tx   = addr_r;
      end
      3'd3: begin
        item = rw_r ? IT_START : IT_WBYTE;
        tx   = wdata_r;
      end
      3'd4: begin
        item = rw_r ? IT_WBYTE : IT_STOP;
        tx   = {`POT_DEV_ID, 1'b1};
      end
      3'd5: item = rw_r ? IT_RBYTE : IT_END;
      3'd6: item = rw_r ? IT_STOP : IT_END;
      default: item = IT_END;
    endcase
  end

  // Each bit is four quarters: lower clock and set data, raise, sample, lower.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 8'h00;
      o_nack  <= 1'b0;
      idx_r   <= 3'd0;
      slot_r  <= 4'h0;
      q_r     <= 2'd0;
      rw_r    <= 1'b0;
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      rx_r    <= 8'h00;
      scl_r   <= 1'b1;
      low_r   <= 1'b0;
      nk_r    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_req) begin
          o_busy  <= 1'b1;
          o_nack  <= 1'b0;
          rw_r    <= i_rw;
          addr_r  <= i_reg_addr;
          wdata_r <= i_wdata;
          idx_r   <= 3'd0;
          slot_r  <= 4'h0;
          q_r     <= 2'd0;
          nk_r    <= 1'b0;
        end
      end else if (item == IT_END) begin
        o_busy  <= 1'b0;
        o_done  <= 1'b1;
        o_rdata <= rx_r;
      end else if (tick) begin
        q_r <= q_r + 2'd1;
        case (q_r)
          2'd0: begin
            scl_r <= 1'b0;
            if (item == IT_START) begin
              low_r <= 1'b0;
            end else if (item == IT_STOP) begin
              low_r <= 1'b1;
            end else if (item == IT_WBYTE && slot_r < 4'd8) begin
              low_r <= ~tx[3'd7 - slot_r[2:0]];
            end else begin
              low_r <= 1'b0;
            end
          end
          2'd1: scl_r <= 1'b1;
          2'd2: begin
            if (item == IT_START) begin
              low_r <= 1'b1;
            end else if (item == IT_STOP) begin
              low_r <= 1'b0;
            end else if (item == IT_RBYTE && slot_r < 4'd8) begin
              rx_r <= {rx_r[6:0], sda_s};
            end else if (item == IT_WBYTE && slot_r == 4'd8) begin
              nk_r <= sda_s;
            end
          end
          default: begin
            scl_r <= (item == IT_STOP);
            if ((item == IT_WBYTE || item == IT_RBYTE) && slot_r != 4'd8) begin
              slot_r <= slot_r + 4'd1;
            end else begin
              slot_r <= 4'h0;
              if (nk_r) begin
                nk_r   <= 1'b0;
                o_nack <= 1'b1;
                idx_r  <= rw_r ? 3'd6 : 3'd4;
              end else begin
                idx_r <= idx_r + 3'd1;
              end
            end
          end
        endcase
      end
    end
  end

  assign bus.scl         = scl_r;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = low_r;
endmodule

// [test/pot_bus_sva.sv]
// Checker for the two-wire bus joining the master end and the potentiometer end.
// Assumes the link clock samples the bus far faster than the bus clock toggles.
`timescale 1ns/1ps
`include "pot_defs.svh"
module pot_bus_sva (
  input wire logic i_lclk,       // Link clock.
  input wire logic i_rst_n,      // Reset, active low.
  input wire logic scl,          // Bus clock.
  input wire logic sda_host_o,   // Master data out.
  input wire logic sda_host_oe,  // Master pull enable.
  input wire logic sda_dev_o,    // Device data out.
  input wire logic sda_dev_oe,   // Device pull enable.
  input wire logic sda           // Resolved data line.
);
  default clocking cb @(posedge i_lclk); endclocking
  default disable iff (!i_rst_n);

  // ---------------------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------------------
  logic       scl_d_r, sda_d_r, idle_r, id_ok_r, rd_r;
  logic [3:0] cnt_r;
  logic [1:0] bidx_r;
  logic [7:0] sh_r;
  wire        start = scl & scl_d_r & sda_d_r & ~sda;
  wire        stop  = scl & scl_d_r & ~sda_d_r & sda;
  wire        rise  = scl & ~scl_d_r;
  wire        nin   = rise & (cnt_r == 4'h8);

  // Previous samples, so edges need no sampled-value functions outside properties.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // Bit and byte counters; a repeated start restarts the byte count.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 4'h0;
      bidx_r <= 2'h0;
      idle_r <= 1'b1;
    end else if (start) begin
      cnt_r  <= 4'h0;
      bidx_r <= 2'h0;
      idle_r <= 1'b0;
    end else if (stop) begin
      idle_r <= 1'b1;
    end else if (rise) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      if (cnt_r == 4'h9 && bidx_r != 2'h3) begin
        bidx_r <= bidx_r + 2'h1;
      end
    end
  end

  // Shift register; the ninth rise of the first byte records the id outcome.
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_r    <= 8'h00;
      id_ok_r <= 1'b0;
      rd_r    <= 1'b0;
    end else if (start) begin
      id_ok_r <= 1'b0;
    end else if (rise) begin
      if (cnt_r != 4'h8) begin
        sh_r <= {sh_r[6:0], sda};
      end
      if (nin && bidx_r == 2'h0) begin
        id_ok_r <= ~sda & (sh_r[7:1] == `POT_DEV_ID);
        rd_r    <= sh_r[0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_dev_scl_low;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low)
    else $error("device moved data while clock high");

  property p_high_only_host;
    scl && scl_d_r && $changed(sda) |-> $changed(sda_host_oe);
  endproperty
  a_high_only_host: assert property (p_high_only_host)
    else $error("data moved under high clock not by master");

  property p_pwrup_release;
    $rose(i_rst_n) |-> !sda_dev_oe [*8];
  endproperty
  a_pwrup_release: assert property (p_pwrup_release)
    else $error("device drove data after power-up");

  property p_id_match;
    nin && bidx_r == 2'h0 && !sda |-> sh_r[7:1] == `POT_DEV_ID;
  endproperty
  a_id_match: assert property (p_id_match)
    else $error("id byte acknowledged with wrong pattern");

  property p_addr_ack;
    nin && bidx_r == 2'h1 && id_ok_r && !rd_r |-> sda_dev_oe && !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address byte not acknowledged");

  property p_data_ack;
    nin && bidx_r == 2'h2 && id_ok_r && !rd_r |-> sda_dev_oe;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("write data byte not acknowledged");

  property p_ack_window;
    id_ok_r && !rd_r && bidx_r != 2'h0 && sda_dev_oe |-> cnt_r inside {4'h8, 4'h9};
  endproperty
  a_ack_window: assert property (p_ack_window)
    else $error("device drove data outside the ninth clock");

  property p_idle_quiet;
    idle_r |-> !sda_dev_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("device drove data outside a frame");
endmodule

// [test/i2c_slave_pot_register_port_tb_top.sv]
// Testbench joining the master end and the potentiometer end over one bus.
// Assumes both ends share one reset; the NV write is shortened by parameter.
`timescale 1ns/1ps
module i2c_slave_pot_register_port_tb_top;
  logic       mclk = 1'b0, lclk = 1'b1, rst_n = 1'b0, req = 1'b0, rw = 1'b0;
  logic [7:0] reg_addr = 8'h00, wdata = 8'h00, rdata, wiper, nv_value, access_sel;
  logic       busy, done, nack, nv_busy, ready;
  int         fails = 0, total_checks = 0, cyc = 0;

  always #12.5 mclk = ~mclk;
  always #3 lclk = ~lclk;

  pot_bus_if bus ();
  pot_master pot_master_inst (.i_mclk(mclk), .i_rst_n(rst_n), .bus(bus), .i_req(req),
    .i_rw(rw), .i_reg_addr(reg_addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_nack(nack));
  // NV write long enough that a following id byte lands inside it.
  pot_slave #(.NV_CYCLES(6000)) pot_slave_inst (.i_lclk(lclk), .i_rst_n(rst_n), .bus(bus),
    .o_wiper(wiper), .o_nv_value(nv_value), .o_access_sel(access_sel), .o_nv_busy(nv_busy),
    .o_ready(ready));
  pot_bus_sva pot_bus_sva_inst (.i_lclk(lclk), .i_rst_n(rst_n), .scl(bus.scl),
    .sda_host_o(bus.sda_host_o), .sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o),
    .sda_dev_oe(bus.sda_dev_oe), .sda(bus.sda));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One whole transaction; waits for the completion pulse under a bound.
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    #2 req = 1'b1;
    rw = r;
    reg_addr = a;
    wdata = d;
    @(posedge mclk);
    #2 req = 1'b0;
    while (done !== 1'b1 && n < 8000) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 8000) fails++;
  endtask

  // Waits until the NV write flag shows the given level, under a bound.
  task automatic wait_nv(input logic lvl);
    int n;
    n = 0;
    while (nv_busy !== lvl && n < 4000) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 4000) fails++;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_pwrup();
    while (ready !== 1'b1 && cyc < 200) @(posedge mclk);
    chk("ready", 8'h01, {7'h0, ready});
    chk("wiper", 8'h80, wiper);
    chk("nv", 8'h80, nv_value);
    chk("sel", 8'h00, access_sel);
    $display("test pwrup done");
  endtask

  // NV write, then a write that lands inside the busy time and is ignored.
  task automatic t_nv_write();
    xfer(1'b0, 8'h00, 8'hA5);
    chk("mbusy", 8'h00, {7'h0, busy});
    chk("wiper", 8'hA5, wiper);
    chk("nack", 8'h00, {7'h0, nack});
    wait_nv(1'b1);
    chk("busy", 8'h01, {7'h0, nv_busy});
    xfer(1'b0, 8'h02, 8'h80);
    chk("nack", 8'h01, {7'h0, nack});
    chk("sel", 8'h00, access_sel);
    wait_nv(1'b0);
    chk("busy", 8'h00, {7'h0, nv_busy});
    chk("nv", 8'hA5, nv_value);
    $display("test nv_write done");
  endtask

  task automatic t_vol_write();
    xfer(1'b0, 8'h02, 8'h80);
    chk("sel", 8'h80, access_sel);
    xfer(1'b0, 8'h00, 8'h3C);
    chk("wiper", 8'h3C, wiper);
    chk("nv", 8'hA5, nv_value);
    $display("test vol_write done");
  endtask

  // Reads right after a volatile write: an ack proves no NV cycle started.
  task automatic t_read();
    xfer(1'b1, 8'h00, 8'h00);
    chk("nack", 8'h00, {7'h0, nack});
    chk("rdata", 8'h3C, rdata);
    xfer(1'b1, 8'h02, 8'h00);
    chk("rdata", 8'h80, rdata);
    xfer(1'b0, 8'h02, 8'h00);
    xfer(1'b1, 8'h00, 8'h00);
    chk("rdata", 8'hA5, rdata);
    $display("test read done");
  endtask

  task automatic t_reserved();
    xfer(1'b0, 8'h01, 8'h5A);
    chk("nack", 8'h00, {7'h0, nack});
    chk("wiper", 8'h3C, wiper);
    chk("sel", 8'h00, access_sel);
    xfer(1'b1, 8'h01, 8'h00);
    chk("rdata", 8'h00, rdata);
    chk("busy", 8'h00, {7'h0, nv_busy});
    $display("test reserved done");
  endtask

  // Hang guard: the full sequence needs about 32000 cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    #2 rst_n = 1'b1;
    t_pwrup();
    t_nv_write();
    t_vol_write();
    t_read();
    t_reserved();
    finish_test();
  end
endmodule
